// file: core/kps_pkg.sv
// Package for the keypad configuration and raw status block.
// Assumes a single 25 MHz clock shared by the scan engine and register port.
package kps_pkg;
    // Register offsets on the byte-wide register port
    localparam logic [7:0] ADDR_DEBOUNCE  = 8'h02;
    localparam logic [7:0] ADDR_SIZE      = 8'h03;
    localparam logic [7:0] ADDR_DED_HI    = 8'h04;
    localparam logic [7:0] ADDR_DED_LO    = 8'h05;
    localparam logic [7:0] ADDR_RAW_STAT  = 8'h06;
    localparam logic [7:0] ADDR_CLEAR     = 8'h08;
    // Reset values
    localparam logic [7:0]  RST_DEBOUNCE  = 8'h80;
    localparam logic [3:0]  RST_ROWS      = 4'h2;
    localparam logic [3:0]  RST_COLS      = 4'h2;
    localparam logic [15:0] RST_DED       = 16'hFFFF;
    // Field positions
    localparam int SIZE_ROW_LSB  = 4;
    localparam int SIZE_COL_LSB  = 0;
    localparam int DED_ROW_LSB   = 10;
    localparam int DED_COLH_LSB  = 8;
    localparam int DED_COLL_LSB  = 0;
    localparam int ST_OVF        = 3;
    localparam int ST_PEND       = 2;
    localparam int ST_LOST       = 1;
    localparam int ST_SCAN       = 0;
    localparam int CLR_EVT       = 1;
    localparam int CLR_SCAN      = 0;
    // Key-count limit before a key is lost
    localparam logic [3:0] MAX_HELD = 4'h4;
    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
    localparam logic [4:0] DEB_MS_16 = 5'h10;
    localparam logic [4:0] DEB_MS_12 = 5'h0C;
    localparam logic [4:0] DEB_MS_8  = 5'h08;
    localparam logic [4:0] DEB_MS_4  = 5'h04;

    // Events arriving from the scan engine and event queue
    typedef struct packed {
        logic       keyChange;    // First sight of a key change
        logic       scanDone;     // End of one matrix scan
        logic       scanChanged;  // That scan differed from the last
        logic       keyEvent;     // New press or release detected
        logic       evtPush;      // Event written into the queue
        logic       evtOverflow;  // Queue overflowed
        logic       evtDrained;   // Host read emptied the event queue
        logic       codeDrained;  // Host read emptied the scan codes
        logic [3:0] heldKeys;     // Keys currently held
    } kps_evt_t;

    // Configuration handed to the scan engine and pin mux
    typedef struct packed {
        logic [3:0]  rowCount;
        logic [3:0]  colCount;
        logic        rowsFree;    // All row balls released
        logic        colsFree;    // All column balls released
        logic [7:0]  dedRow;      // 1 = row ball is a dedicated key
        logic [11:0] dedCol;      // 1 = column ball is a dedicated key
    } kps_cfg_t;

    // Interval in ms chosen by the debounce setting, 0 = none
    function automatic logic [4:0] debounceMs(input logic [7:0] s);
        if (s[7:6] == 2'b11) begin
            debounceMs = DEB_MS_16;
        end else if (s[7:6] == 2'b10) begin
            debounceMs = DEB_MS_12;
        end else if (s[7:6] == 2'b01) begin
            debounceMs = DEB_MS_8;
        end else if (s != 8'h00) begin
            debounceMs = DEB_MS_4;
        end else begin
            debounceMs = 5'h00;
        end
    endfunction
endpackage

// file: core/kps_debounce_timer.sv
// Debounce interval timer: waits the programmed interval after a key change.
// Assumes start and setting come from logic on the same clock.
`timescale 1ns/1ps
module kps_debounce_timer #(
    parameter int CYC_PER_MS = kps_pkg::MS_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rstSync_n,
    input  wire logic       ce,
    input  wire logic       start,
    input  wire logic [7:0] setting,
    output logic            confirm,
    output logic            busy
);
    import kps_pkg::*;

    logic [23:0] msCnt;        // Cycles within current ms
    logic [4:0]  msLeft;       // Whole ms still to wait
    logic        next_confirm;
    logic        next_busy;
    logic [23:0] next_msCnt;
    logic [4:0]  next_msLeft;
    logic        msWrap;       // Last cycle of a ms

    assign msWrap = (msCnt == 24'(CYC_PER_MS - 1));

    // Interval countdown, a fresh change restarts it
    always_comb begin
        next_confirm = 1'b0;
        next_busy    = busy;
        next_msCnt   = msCnt;
        next_msLeft  = msLeft;
        if (start) begin
            next_msCnt = 24'h000000;
            if (debounceMs(setting) == 5'h00) begin
                // No debouncing: confirm at once
                next_confirm = 1'b1;
                next_busy    = 1'b0;
            end else begin
                next_msLeft = debounceMs(setting);
                next_busy   = 1'b1;
            end
        end else if (busy) begin
            next_msCnt = msWrap ? 24'h000000 : msCnt + 24'h000001;
            if (msWrap) begin
                next_msLeft = msLeft - 5'h01;
                if (msLeft == 5'h01) begin
                    // Final sample after the interval
                    next_confirm = 1'b1;
                    next_busy    = 1'b0;
                end
            end
        end
    end

    // State registers
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            confirm <= 1'b0;
            busy    <= 1'b0;
            msCnt   <= 24'h000000;
            msLeft  <= 5'h00;
        end else if (ce) begin
            confirm <= next_confirm;
            busy    <= next_busy;
            msCnt   <= next_msCnt;
            msLeft  <= next_msLeft;
        end
    end

    AST_DEB_ZERO: assert property (@(posedge clk) disable iff (!rstSync_n)
        (ce && start && setting == 8'h00) |=> confirm)
        else $error("zero setting did not confirm at once");
    AST_DEB_WAIT: assert property (@(posedge clk) disable iff (!rstSync_n)
        (ce && start && setting != 8'h00) |=> (busy && !confirm))
        else $error("debounce did not wait");
endmodule

// file: core/kps_config_status.sv
// Keypad configuration and raw status registers with debounce timing.
// Assumes a byte-wide register port and scan engine on the same clock.
// What this block does
// - Debounce waits from change to final sample
// - Setting range selects 16/12/8/4 ms or none
// - Debounce setting resets to 0x80, 12 ms
// - Row count bits 7:4, reset 2, 2..8
// - Zero rows frees rows, rows 1:0 dedicated while scan enabled
// - Column count bits 3:0, reset 2, 2..12
// - Zero columns frees columns, columns 1:0 dedicated while scan enabled
// - Select bit 0 makes ball dedicated key
// - Bits 15:10 are rows 7..2, reset 3F
// - Bits 9:8 are columns 11,10, reset 3
// - Bits 7:0 are columns 9..2, reset FF
// - Raw status read-only, bits 7:4 zero
// - Overflow flag bit 3, cleared by queue clear
// - Pending flag bit 2 while events queued
// - Key lost on event during scan flag
// - Scan-change flag set when scan differs
// - Draining scan codes clears scan-change flag
// - Clear bit 1 flushes queue, pending, overflow
// - Clear bit 0 clears scan-change, key lost
`timescale 1ns/1ps
module kps_config_status #(
    parameter int CYC_PER_MS = kps_pkg::MS_CYCLES
) (
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic            ce,
    input  wire logic [7:0]      regAddr,
    input  wire logic [7:0]      regWrData,
    input  wire logic            regWr,
    input  wire logic            regRd,
    output logic      [7:0]      regRdData,
    input  wire logic            keypadScanEnable,
    input  wire kps_pkg::kps_evt_t evt,
    output kps_pkg::kps_cfg_t    cfg,
    output logic                 debounceConfirm,
    output logic                 debounceBusy,
    output logic                 evtQueueFlush,
    output logic      [3:0]      rawStatus
);
    import kps_pkg::*;

    // Reset synchroniser
    logic rstMeta_n;
    logic rstSync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_n <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_n <= 1'b1;
            rstSync_n <= rstMeta_n;
        end
    end

    // Programmable registers
    logic [7:0]  debounceTime;          // Debounce setting
    logic [3:0]  rowCountField;         // Matrix rows
    logic [3:0]  columnCountField;      // Matrix columns
    logic [15:0] dedicatedKeySelect;    // 0 = dedicated key
    logic [7:0]  next_debounceTime;
    logic [3:0]  next_rowCountField;
    logic [3:0]  next_columnCountField;
    logic [15:0] next_dedicatedKeySelect;

    // Raw status flags
    logic eventOverflowFlag;
    logic eventPendingFlag;
    logic keyLostFlag;
    logic scanChangeFlag;
    logic next_eventOverflowFlag;
    logic next_eventPendingFlag;
    logic next_keyLostFlag;
    logic next_scanChangeFlag;

    // Register port outputs
    logic [7:0] next_regRdData;
    logic       next_evtQueueFlush;
    logic       wrClear;            // Write to clear register
    logic       clrEvt;             // Queue clear bit written
    logic       clrScan;            // Scan flag clear bit written
    logic       heldOver;           // Too many keys held

    assign wrClear  = regWr && (regAddr == ADDR_CLEAR);
    assign clrEvt   = wrClear && regWrData[CLR_EVT];
    assign clrScan  = wrClear && regWrData[CLR_SCAN];
    assign heldOver = (evt.heldKeys > MAX_HELD);

    // Configuration register writes
    always_comb begin
        next_debounceTime       = debounceTime;
        next_rowCountField      = rowCountField;
        next_columnCountField   = columnCountField;
        next_dedicatedKeySelect = dedicatedKeySelect;
        if (regWr) begin
            case (regAddr)
                ADDR_DEBOUNCE: begin
                    next_debounceTime = regWrData;
                end
                ADDR_SIZE: begin
                    // Value one is illegal and taken as written
                    next_rowCountField    = regWrData[SIZE_ROW_LSB +: 4];
                    next_columnCountField = regWrData[SIZE_COL_LSB +: 4];
                end
                ADDR_DED_HI: begin
                    next_dedicatedKeySelect[15:8] = regWrData;
                end
                ADDR_DED_LO: begin
                    next_dedicatedKeySelect[7:0] = regWrData;
                end
                default: begin
                    // Status and clear have no stored bits here
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            debounceTime       <= RST_DEBOUNCE;
            rowCountField      <= RST_ROWS;
            columnCountField   <= RST_COLS;
            dedicatedKeySelect <= RST_DED;
        end else if (ce) begin
            debounceTime       <= next_debounceTime;
            rowCountField      <= next_rowCountField;
            columnCountField   <= next_columnCountField;
            dedicatedKeySelect <= next_dedicatedKeySelect;
        end
    end

    // Status flags: hardware set wins over any clear in the same cycle
    always_comb begin
        // Overflow stays until the queue clear bit
        next_eventOverflowFlag = evt.evtOverflow
            || (eventOverflowFlag && !clrEvt);
        // Pending while queued, dropped on drain or flush
        next_eventPendingFlag = evt.evtPush
            || (eventPendingFlag && !evt.evtDrained && !clrEvt);
        // Lost key: event while scan flag still up, or too many held
        next_keyLostFlag = (evt.keyEvent && scanChangeFlag) || heldOver
            || (keyLostFlag && !clrScan);
        // Scan change: set after a differing scan
        next_scanChangeFlag = (evt.scanDone && evt.scanChanged)
            || (scanChangeFlag && !evt.codeDrained && !clrScan);
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            eventOverflowFlag <= 1'b0;
            eventPendingFlag  <= 1'b0;
            keyLostFlag       <= 1'b0;
            scanChangeFlag    <= 1'b0;
        end else if (ce) begin
            eventOverflowFlag <= next_eventOverflowFlag;
            eventPendingFlag  <= next_eventPendingFlag;
            keyLostFlag       <= next_keyLostFlag;
            scanChangeFlag    <= next_scanChangeFlag;
        end
    end

    assign rawStatus = {eventOverflowFlag, eventPendingFlag, keyLostFlag, scanChangeFlag};

    // Read mux and queue flush strobe
    always_comb begin
        next_regRdData     = regRdData;
        next_evtQueueFlush = clrEvt;
        if (regRd) begin
            case (regAddr)
                ADDR_DEBOUNCE: next_regRdData = debounceTime;
                ADDR_SIZE:     next_regRdData = {rowCountField, columnCountField};
                ADDR_DED_HI:   next_regRdData = dedicatedKeySelect[15:8];
                ADDR_DED_LO:   next_regRdData = dedicatedKeySelect[7:0];
                ADDR_RAW_STAT: next_regRdData = {4'h0, rawStatus};
                default:       next_regRdData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            regRdData     <= 8'h00;
            evtQueueFlush <= 1'b0;
        end else if (ce) begin
            regRdData     <= next_regRdData;
            evtQueueFlush <= next_evtQueueFlush;
        end
    end

    // Ball configuration for the scan engine and pin mux
    always_comb begin
        cfg.rowCount = rowCountField;
        cfg.colCount = columnCountField;
        cfg.rowsFree = (rowCountField == 4'h0);
        cfg.colsFree = (columnCountField == 4'h0);
        // Select bits are active low for the dedicated function
        cfg.dedRow[7:2]   = ~dedicatedKeySelect[DED_ROW_LSB +: 6];
        cfg.dedCol[11:10] = ~dedicatedKeySelect[DED_COLH_LSB +: 2];
        cfg.dedCol[9:2]   = ~dedicatedKeySelect[DED_COLL_LSB +: 8];
        // Lowest two balls become dedicated keys when released and scan is enabled
        cfg.dedRow[1:0] = {2{cfg.rowsFree && keypadScanEnable}};
        cfg.dedCol[1:0] = {2{cfg.colsFree && keypadScanEnable}};
    end

    // Debounce interval timer
    kps_debounce_timer #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_timer (
        .clk       (clk),
        .rstSync_n (rstSync_n),
        .ce        (ce),
        .start     (evt.keyChange),
        .setting   (debounceTime),
        .confirm   (debounceConfirm),
        .busy      (debounceBusy)
    );

    // Checks on the flag and register behaviour
    AST_OVF_SET: assert property (@(posedge clk) disable iff (!rstSync_n)
        (ce && evt.evtOverflow) |=> rawStatus[ST_OVF])
        else $error("overflow flag not set");
    AST_OVF_HOLD: assert property (@(posedge clk) disable iff (!rstSync_n)
        (ce && eventOverflowFlag && !clrEvt) |=> eventOverflowFlag)
        else $error("overflow flag dropped without queue clear");
    AST_EVT_CLR: assert property (@(posedge clk) disable iff (!rstSync_n)
        (ce && clrEvt && !evt.evtOverflow && !evt.evtPush)
        |=> (!eventOverflowFlag && !eventPendingFlag && evtQueueFlush))
        else $error("queue clear failed");
    AST_PEND_DRAIN: assert property (@(posedge clk) disable iff (!rstSync_n)
        (ce && evt.evtDrained && !evt.evtPush) |=> !eventPendingFlag)
        else $error("pending flag not cleared on drain");
    AST_LOST_EVT: assert property (@(posedge clk) disable iff (!rstSync_n)
        (ce && evt.keyEvent && scanChangeFlag) |=> keyLostFlag)
        else $error("key lost not flagged on event");
    AST_LOST_HELD: assert property (@(posedge clk) disable iff (!rstSync_n)
        (ce && evt.heldKeys == 4'h5) |=> keyLostFlag)
        else $error("key lost not flagged on five held");
    AST_SCAN_SET: assert property (@(posedge clk) disable iff (!rstSync_n)
        (ce && !scanChangeFlag && evt.scanDone && !evt.scanChanged) |=> !scanChangeFlag)
        else $error("scan flag set without change");
    AST_SCAN_DRAIN: assert property (@(posedge clk) disable iff (!rstSync_n)
        (ce && evt.codeDrained && !evt.scanDone) |=> !scanChangeFlag)
        else $error("scan flag kept after drain");
    AST_SCAN_CLR: assert property (@(posedge clk) disable iff (!rstSync_n)
        (ce && clrScan && !evt.scanDone && !evt.keyEvent && !heldOver)
        |=> (!scanChangeFlag && !keyLostFlag))
        else $error("scan flag clear failed");
    AST_STAT_RD: assert property (@(posedge clk) disable iff (!rstSync_n)
        (ce && regRd && regAddr == ADDR_RAW_STAT)
        |=> (regRdData == {4'h0, $past(rawStatus)}))
        else $error("raw status read wrong");
    AST_FREE_ROWS: assert property (@(posedge clk) disable iff (!rstSync_n)
        (rowCountField == 4'h0 && keypadScanEnable) |-> (cfg.dedRow[1:0] == 2'b11))
        else $error("rows 1:0 not dedicated when free");
    AST_DED_MAP: assert property (@(posedge clk) disable iff (!rstSync_n)
        (cfg.dedCol[9:2] == ~dedicatedKeySelect[7:0]) && (cfg.dedRow[7:2] == ~dedicatedKeySelect[15:10]))
        else $error("dedicated map wrong");
    AST_RST_DEB: assert property (@(posedge clk)
        $rose(rstSync_n) |-> (debounceTime == 8'h80))
        else $error("debounce reset value wrong");
    AST_RST_SIZE: assert property (@(posedge clk)
        $rose(rstSync_n) |-> (cfg.rowCount == RST_ROWS && cfg.colCount == RST_COLS))
        else $error("size reset value wrong");
    AST_RST_DED: assert property (@(posedge clk)
        $rose(rstSync_n) |-> (dedicatedKeySelect == RST_DED))
        else $error("dedicated select reset value wrong");

    // Register writes land one cycle after the strobe
    AST_DEB_WR: assert property (@(posedge clk) disable iff (!rstSync_n)
        (ce && regWr && regAddr == ADDR_DEBOUNCE) |=> (debounceTime == $past(regWrData)))
        else $error("debounce write lost");
    AST_SIZE_WR: assert property (@(posedge clk) disable iff (!rstSync_n)
        (ce && regWr && regAddr == ADDR_SIZE) |=> (cfg.rowCount == $past(regWrData[7:4])))
        else $error("row count write lost");
    AST_COL_WR: assert property (@(posedge clk) disable iff (!rstSync_n)
        (ce && regWr && regAddr == ADDR_SIZE) |=> (cfg.colCount == $past(regWrData[3:0])))
        else $error("column count write lost");

    // Ball mapping follows the written select bytes, zero means dedicated
    AST_DED_HI_WR: assert property (@(posedge clk) disable iff (!rstSync_n)
        (ce && regWr && regAddr == ADDR_DED_HI) |=> (cfg.dedRow[7:2] == ~$past(regWrData[7:2])))
        else $error("row dedicated map wrong");
    AST_COLH_WR: assert property (@(posedge clk) disable iff (!rstSync_n)
        (ce && regWr && regAddr == ADDR_DED_HI) |=> (cfg.dedCol[11:10] == ~$past(regWrData[1:0])))
        else $error("upper column dedicated map wrong");
    AST_DED_LO_WR: assert property (@(posedge clk) disable iff (!rstSync_n)
        (ce && regWr && regAddr == ADDR_DED_LO) |=> (cfg.dedCol[9:2] == ~$past(regWrData)))
        else $error("lower column dedicated map wrong");
    AST_FREE_COLS: assert property (@(posedge clk) disable iff (!rstSync_n)
        (columnCountField == 4'h0 && keypadScanEnable) |-> (cfg.dedCol[1:0] == 2'b11))
        else $error("columns 1:0 not dedicated when free");
    AST_NOT_FREE: assert property (@(posedge clk) disable iff (!rstSync_n)
        !keypadScanEnable |-> (cfg.dedRow[1:0] == 2'b00 && cfg.dedCol[1:0] == 2'b00))
        else $error("low balls dedicated while scan off");

    // Flags rise one cycle after their event
    AST_PEND_SET: assert property (@(posedge clk) disable iff (!rstSync_n)
        (ce && evt.evtPush) |=> rawStatus[ST_PEND])
        else $error("pending flag not set on push");
    AST_SCAN_CHG: assert property (@(posedge clk) disable iff (!rstSync_n)
        (ce && evt.scanDone && evt.scanChanged) |=> rawStatus[ST_SCAN])
        else $error("scan flag not set on change");
    AST_FLUSH_ONE: assert property (@(posedge clk) disable iff (!rstSync_n)
        (ce && !clrEvt) |=> !evtQueueFlush)
        else $error("queue flush without clear bit");
endmodule

// file: bench/kps_matrix_model.sv
// Switch matrix and scan engine stand-in that drives the event struct.
// Assumes the bench calls its tasks from the same clock domain.
`timescale 1ns/1ps
module kps_matrix_model (
    input  wire logic         clk,
    output kps_pkg::kps_evt_t evt
);
    import kps_pkg::*;

    // Idle: no pulses, no keys held
    initial evt = '0;

    // One-cycle pulse; mask bits keyChange down to codeDrained
    task automatic pulse(input logic [7:0] m);
        @(posedge clk);
        #1;
        {evt.keyChange, evt.scanDone, evt.scanChanged, evt.keyEvent,
         evt.evtPush, evt.evtOverflow, evt.evtDrained, evt.codeDrained} = m;
        @(posedge clk);
        #1;
        {evt.keyChange, evt.scanDone, evt.scanChanged, evt.keyEvent,
         evt.evtPush, evt.evtOverflow, evt.evtDrained, evt.codeDrained} = 8'h00;
    endtask

    // Held key count as a level, one edge allowed to land
    task automatic setHeld(input logic [3:0] v);
        @(posedge clk);
        #1;
        evt.heldKeys = v;
        @(posedge clk);
        #1;
    endtask
endmodule

// file: bench/keypad_scan_config_irq_status_bench.sv
// Self-checking bench for the keypad configuration and raw status block.
// Assumes the design package and the matrix model are compiled first.
`timescale 1ns/1ps
module keypad_scan_config_irq_status_bench;
    import kps_pkg::*;
    localparam int CPM   = 4;        // Shortened cycles per millisecond
    localparam int LIMIT = 20000;    // Cycle ceiling for the whole run
    logic       clk, rst_n, ce, regWr, regRd, keypadScanEnable;
    logic [7:0] regAddr, regWrData, regRdData, rv;
    logic [15:0] dk;
    kps_evt_t   evt;
    kps_cfg_t   cfg;
    logic       debounceConfirm, debounceBusy, evtQueueFlush;
    logic [3:0] rawStatus;
    int         fail_count = 0, n_compared = 0, cycles = 0, n;
    logic [7:0] settings [8] = '{8'hC0, 8'hFF, 8'hBF, 8'h40, 8'h7F, 8'h3F, 8'h01, 8'h00};

    always #20 clk = ~clk;

    kps_matrix_model MODEL (.clk(clk), .evt(evt));
    kps_config_status #(.CYC_PER_MS(CPM)) DUT (
        .clk(clk), .rst_n(rst_n), .ce(ce), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .keypadScanEnable(keypadScanEnable), .evt(evt), .cfg(cfg),
        .debounceConfirm(debounceConfirm), .debounceBusy(debounceBusy),
        .evtQueueFlush(evtQueueFlush), .rawStatus(rawStatus));

    // Expected cycles from key change to confirm
    function automatic int expLat(input logic [7:0] s);
        if (s == 8'h00) return 1;
        return (s >= 8'hC0 ? 16 : s >= 8'h80 ? 12 : s >= 8'h40 ? 8 : 4) * CPM + 1;
    endfunction

    task automatic end_of_test();
        if (fail_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Register read: strobe one cycle, data valid after the taken edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        regAddr = a;
        regRd = 1'b1;
        @(posedge clk);
        #1;
        regRd = 1'b0;
        d = regRdData;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        regAddr = a;
        regWrData = d;
        regWr = 1'b1;
        @(posedge clk);
        #1;
        regWr = 1'b0;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(d, e);
    endtask

    // Key change, then count cycles until the confirm pulse
    task automatic lat(input logic [7:0] s, input bit doWrite);
        if (doWrite) wr(ADDR_DEBOUNCE, s);
        MODEL.pulse(8'h80);
        if (s != 8'h00) chk(debounceBusy, 1'b1);
        n = 1;
        while (debounceConfirm !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n, expLat(s));
        @(posedge clk);
        #1;
        chk({debounceConfirm, debounceBusy}, 2'b00);
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            end_of_test();
        end
    end

    initial begin
        {clk, rst_n, ce, regWr, regRd, keypadScanEnable} = 6'b001000;
        {regAddr, regWrData} = 16'h0000;
        rv = 8'($urandom(32'h7846));
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clk);
        // Reset values and unmapped places
        rdChk(ADDR_DEBOUNCE, 8'h80);
        rdChk(ADDR_SIZE, 8'h22);
        rdChk(ADDR_DED_HI, 8'hFF);
        rdChk(ADDR_DED_LO, 8'hFF);
        rdChk(ADDR_RAW_STAT, 8'h00);
        rdChk(ADDR_CLEAR, 8'h00);
        rdChk(8'h0F, 8'h00);
        chk({cfg.dedRow, cfg.dedCol}, 20'h0);
        lat(8'h80, 1'b0);
        // Matrix size fields
        wr(ADDR_SIZE, 8'h48);
        chk({cfg.rowCount, cfg.colCount}, 8'h48);
        wr(ADDR_SIZE, 8'h8C);
        rdChk(ADDR_SIZE, 8'h8C);
        keypadScanEnable = 1'b1;
        wr(ADDR_SIZE, 8'h00);
        chk({cfg.rowsFree, cfg.colsFree, cfg.dedRow[1:0], cfg.dedCol[1:0]}, 6'h3F);
        keypadScanEnable = 1'b0;
        #1 chk({cfg.rowsFree, cfg.colsFree, cfg.dedRow[1:0], cfg.dedCol[1:0]}, 6'h30);
        wr(ADDR_SIZE, 8'h22);
        // Frozen clock enable ignores a write
        ce = 1'b0;
        wr(ADDR_SIZE, 8'h55);
        ce = 1'b1;
        rdChk(ADDR_SIZE, 8'h22);
        // Dedicated key selection, corner then random
        for (int i = 0; i < 5; i++) begin
            dk = (i == 0) ? 16'h0000 : 16'($urandom());
            // Counts are non-zero here, so low balls stay off either way
            keypadScanEnable = 1'($urandom());
            wr(ADDR_DED_HI, dk[15:8]);
            wr(ADDR_DED_LO, dk[7:0]);
            chk({cfg.dedRow, cfg.dedCol}, {~dk[15:10], 2'b00, ~dk[9:0], 2'b00});
            rdChk(ADDR_DED_HI, dk[15:8]);
            rdChk(ADDR_DED_LO, dk[7:0]);
        end
        // Status is read-only
        wr(ADDR_RAW_STAT, 8'hFF);
        rdChk(ADDR_RAW_STAT, 8'h00);
        // Debounce ranges and one random setting
        foreach (settings[i]) lat(settings[i], 1'b1);
        lat(rv, 1'b1);
        // Raw status flags
        MODEL.pulse(8'h04);
        chk(rawStatus, 4'h8);
        MODEL.pulse(8'h08);
        chk(rawStatus, 4'hC);
        fork
            wr(ADDR_CLEAR, 8'h02);
            MODEL.pulse(8'h08);
        join
        chk({evtQueueFlush, rawStatus}, 5'h14);
        @(posedge clk);
        #1 chk(evtQueueFlush, 1'b0);
        MODEL.pulse(8'h02);
        chk(rawStatus, 4'h0);
        MODEL.pulse(8'h40);
        chk(rawStatus, 4'h0);
        MODEL.pulse(8'h60);
        chk(rawStatus, 4'h1);
        MODEL.pulse(8'h10);
        chk(rawStatus, 4'h3);
        rdChk(ADDR_RAW_STAT, 8'h03);
        MODEL.pulse(8'h01);
        chk(rawStatus, 4'h2);
        wr(ADDR_CLEAR, 8'h01);
        chk(rawStatus, 4'h0);
        MODEL.setHeld(4'h4);
        chk(rawStatus, 4'h0);
        MODEL.setHeld(4'h5);
        chk(rawStatus, 4'h2);
        MODEL.setHeld(4'h0);
        MODEL.pulse(8'h04);
        wr(ADDR_CLEAR, 8'h01);
        chk(rawStatus, 4'h8);
        wr(ADDR_CLEAR, 8'h02);
        chk(rawStatus, 4'h0);
        // Mid-run reset brings back the defaults
        wr(ADDR_DEBOUNCE, 8'h11);
        MODEL.pulse(8'h04);
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        chk(rawStatus, 4'h0);
        repeat (3) @(posedge clk);
        rdChk(ADDR_DEBOUNCE, 8'h80);
        end_of_test();
    end
endmodule
